// [verilog/ivt_pkg.sv]
`default_nettype none
package ivt_pkg;
  // ----------------------------------------
  // command codes
  // ----------------------------------------
  localparam logic [7:0] CMD_INPUT_START_THRESHOLD = 8'h35;
  localparam logic [7:0] CMD_INPUT_STOP_THRESHOLD = 8'h36;
  localparam logic [7:0] CMD_OVERCURRENT_WARNING_THRESHOLD = 8'h4a;
  // ----------------------------------------
  // field layout and reset values
  // ----------------------------------------
  localparam int FIELD_W = 12;
  localparam int FIELD_LSB = 0;
  localparam logic [3:0] FIXED_UPPER = 4'h0;
  localparam logic [11:0] START_RESET = 12'h01d;
  localparam logic [11:0] STOP_RESET = 12'h01b;
  localparam logic [11:0] OC_WARN_RESET = 12'hfff;
  localparam int LSB_MV = 250;
  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [0:0] {
    IVT_STOPPED = 1'b0,
    IVT_RUNNING = 1'b1
  } ivt_run_t;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] code;
    logic [15:0] wdata;
  } ivt_cmd_t;
  typedef struct packed {
    logic ack;
    logic nack;
    logic [15:0] rdata;
  } ivt_rsp_t;
endpackage
`default_nettype wire

// [verilog/ivt_regs.sv]
// What this block does
// - start conversion when input reaches start threshold and other conditions hold.
// - while running, stop conversion when input falls to stop threshold.
// - start threshold counts are unsigned, 250 mV each.
// - start threshold resets to 0x001D, meaning 7.25 V.
// - stop threshold counts are unsigned, 250 mV each.
// - stop threshold resets to 0x001B, meaning 6.75 V.
// - upper threshold bits read fixed; low value bits are read/write.
// - current above warning threshold sets byte and word flags, pulls alert low.
// - over-current warning threshold is writable and readable by its code.
`default_nettype none
module ivt_regs
(
  input wire logic SYS_CLK,
  input wire logic RESET,
  input wire ivt_pkg::ivt_cmd_t CMD,
  output var ivt_pkg::ivt_rsp_t RSP,
  input wire logic [11:0] VIN_COUNTS,
  input wire logic [11:0] IOUT_COUNTS,
  input wire logic POWER_UP_OK,
  input wire logic CLEAR_WARN,
  output logic CONVERT_EN,
  output logic STATUS_BYTE_OC_WARN,
  output logic STATUS_WORD_OC_WARN,
  output logic ALERT_LINE_N
);
  import ivt_pkg::*;

  // ----------------------------------------
  // threshold registers
  // ----------------------------------------
  logic [11:0] start_r, start_nxt;
  logic [11:0] stop_r, stop_nxt;
  logic [11:0] ocw_r, ocw_nxt;
  ivt_rsp_t rsp_r, rsp_nxt;

  always_comb
  begin
    start_nxt = start_r;
    stop_nxt = stop_r;
    ocw_nxt = ocw_r;
    rsp_nxt = '0;
    if (CMD.wr)
    begin
      rsp_nxt.ack = 1'b1;
      // only the low value field takes the write
      case (CMD.code)
        CMD_INPUT_START_THRESHOLD:
          start_nxt = CMD.wdata[FIELD_LSB +: FIELD_W];
        CMD_INPUT_STOP_THRESHOLD:
          stop_nxt = CMD.wdata[FIELD_LSB +: FIELD_W];
        CMD_OVERCURRENT_WARNING_THRESHOLD:
          ocw_nxt = CMD.wdata[FIELD_LSB +: FIELD_W];
        default:
        begin
          rsp_nxt.ack = 1'b0;
          rsp_nxt.nack = 1'b1;
        end
      endcase
    end
    else if (CMD.rd)
    begin
      rsp_nxt.ack = 1'b1;
      case (CMD.code)
        CMD_INPUT_START_THRESHOLD:
          rsp_nxt.rdata = {FIXED_UPPER, start_r};
        CMD_INPUT_STOP_THRESHOLD:
          rsp_nxt.rdata = {FIXED_UPPER, stop_r};
        CMD_OVERCURRENT_WARNING_THRESHOLD:
          rsp_nxt.rdata = {FIXED_UPPER, ocw_r};
        default:
        begin
          rsp_nxt.ack = 1'b0;
          rsp_nxt.nack = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (RESET)
    begin
      start_r <= START_RESET;
      stop_r <= STOP_RESET;
      ocw_r <= OC_WARN_RESET;
      rsp_r <= '0;
    end
    else
    begin
      start_r <= start_nxt;
      stop_r <= stop_nxt;
      ocw_r <= ocw_nxt;
      rsp_r <= rsp_nxt;
    end
  end

  assign RSP = rsp_r;

  // ----------------------------------------
  // run / stop hysteresis
  // ----------------------------------------
  ivt_run_t run_r, run_nxt;
  logic conv_r, conv_nxt;

  // both sides are 250 mV counts, so they compare directly
  always_comb
  begin
    run_nxt = run_r;
    case (run_r)
      IVT_STOPPED:
        if (VIN_COUNTS >= start_r && POWER_UP_OK)
          run_nxt = IVT_RUNNING;
      IVT_RUNNING:
        if (VIN_COUNTS <= stop_r)
          run_nxt = IVT_STOPPED;
      default:
        run_nxt = IVT_STOPPED;
    endcase
    // the enable pin gets its own flop so it leaves no decode behind
    conv_nxt = (run_nxt == IVT_RUNNING);
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (RESET)
    begin
      run_r <= IVT_STOPPED;
      conv_r <= 1'b0;
    end
    else
    begin
      run_r <= run_nxt;
      conv_r <= conv_nxt;
    end
  end

  assign CONVERT_EN = conv_r;

  // ----------------------------------------
  // over-current warning
  // ----------------------------------------
  logic warn_r, warn_nxt;
  logic alert_n_r, alert_n_nxt;

  // a new event in the clear cycle keeps the flag set
  always_comb
  begin
    warn_nxt = warn_r;
    if (CLEAR_WARN)
      warn_nxt = 1'b0;
    if (IOUT_COUNTS > ocw_r)
      warn_nxt = 1'b1;
    alert_n_nxt = ~warn_nxt;
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (RESET)
    begin
      warn_r <= 1'b0;
      alert_n_r <= 1'b1;
    end
    else
    begin
      warn_r <= warn_nxt;
      alert_n_r <= alert_n_nxt;
    end
  end

  assign STATUS_BYTE_OC_WARN = warn_r;
  assign STATUS_WORD_OC_WARN = warn_r;
  assign ALERT_LINE_N = alert_n_r;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RESET);

  a_start_default: assert property (
    $fell(RESET) |-> start_r == START_RESET)
    else $error("start threshold reset value wrong");
  a_stop_default: assert property (
    $fell(RESET) |-> stop_r == STOP_RESET)
    else $error("stop threshold reset value wrong");
  a_run_begins: assert property (
    (!CONVERT_EN && VIN_COUNTS >= start_r && POWER_UP_OK) |=> CONVERT_EN)
    else $error("conversion did not start");
  a_run_halts: assert property (
    (CONVERT_EN && VIN_COUNTS <= stop_r) |=> !CONVERT_EN)
    else $error("conversion did not stop");
  a_stay_stopped: assert property (
    (!CONVERT_EN && (VIN_COUNTS < start_r || !POWER_UP_OK)) |=> !CONVERT_EN)
    else $error("conversion resumed below start threshold");
  a_upper_fixed: assert property (
    RSP.ack |-> RSP.rdata[15:12] == FIXED_UPPER)
    else $error("upper bits not fixed");
  a_oc_flags: assert property (
    (IOUT_COUNTS > ocw_r) |=> STATUS_BYTE_OC_WARN && STATUS_WORD_OC_WARN
      && !ALERT_LINE_N)
    else $error("over-current warning not raised");
  a_oc_readback: assert property (
    (CMD.wr && CMD.code == CMD_OVERCURRENT_WARNING_THRESHOLD)
      ##1 (CMD.rd && !CMD.wr && CMD.code == CMD_OVERCURRENT_WARNING_THRESHOLD)
      |=> RSP.ack && RSP.rdata[11:0] == $past(CMD.wdata[11:0], 2))
    else $error("warning threshold readback mismatch");
  a_start_write: assert property (
    (CMD.wr && CMD.code == CMD_INPUT_START_THRESHOLD)
      |=> start_r == $past(CMD.wdata[11:0]))
    else $error("start threshold write lost");
  a_stop_write: assert property (
    (CMD.wr && CMD.code == CMD_INPUT_STOP_THRESHOLD)
      |=> stop_r == $past(CMD.wdata[11:0]))
    else $error("stop threshold write lost");
  a_ocw_write: assert property (
    (CMD.wr && CMD.code == CMD_OVERCURRENT_WARNING_THRESHOLD)
      |=> ocw_r == $past(CMD.wdata[11:0]))
    else $error("warning threshold write lost");
  a_warn_clear: assert property (
    (CLEAR_WARN && !(IOUT_COUNTS > ocw_r))
      |=> !STATUS_BYTE_OC_WARN && !STATUS_WORD_OC_WARN && ALERT_LINE_N)
    else $error("over-current warning not cleared");

  c_start: cover property (!CONVERT_EN ##1 CONVERT_EN);
  c_stop: cover property (CONVERT_EN ##1 !CONVERT_EN);
  c_warn: cover property (ALERT_LINE_N ##1 !ALERT_LINE_N);
  c_nack: cover property (RSP.nack);
endmodule
`default_nettype wire

// [tb/ivt_host.sv]
`default_nettype none
module ivt_host
  import ivt_pkg::*;
(
  input wire logic SYS_CLK,
  output var ivt_pkg::ivt_cmd_t CMD,
  input wire ivt_pkg::ivt_rsp_t RSP
);
  timeunit 1ns;
  timeprecision 1ns;
  initial CMD = '0;
  // one command per call, held for exactly one taking edge
  task automatic xfer(input logic w, input logic [7:0] c,
    input logic [15:0] d, output ivt_rsp_t r);
    @(posedge SYS_CLK);
    CMD <= '{wr: w, rd: !w, code: c, wdata: d};
    @(posedge SYS_CLK);
    CMD <= '0;
    #1 r = RSP;
  endtask
  // write then read the same code on back-to-back taking edges
  task automatic xfer_pair(input logic [7:0] c, input logic [15:0] d,
    output ivt_rsp_t rw, output ivt_rsp_t rr);
    @(posedge SYS_CLK);
    CMD <= '{wr: 1'b1, rd: 1'b0, code: c, wdata: d};
    @(posedge SYS_CLK);
    CMD <= '{wr: 1'b0, rd: 1'b1, code: c, wdata: 16'h0000};
    #1 rw = RSP;
    @(posedge SYS_CLK);
    CMD <= '0;
    #1 rr = RSP;
  endtask
endmodule
`default_nettype wire

// [tb/tb_top.sv]
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import ivt_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ok = 1'b0;
  logic clr = 1'b0;
  logic [11:0] vin = 12'h000;
  logic [11:0] iout = 12'h000;
  ivt_cmd_t cmd;
  ivt_rsp_t rsp;
  ivt_rsp_t nr;
  logic conv, sbyte, sword, alert_n;
  int errors = 0;
  int comparisons = 0;
  int cycles = 0;
  always #20 clk = ~clk;
  ivt_host host_u (.SYS_CLK(clk), .CMD(cmd), .RSP(rsp));
  ivt_regs dut_u (.SYS_CLK(clk), .RESET(rst), .CMD(cmd), .RSP(rsp),
    .VIN_COUNTS(vin), .IOUT_COUNTS(iout), .POWER_UP_OK(ok),
    .CLEAR_WARN(clr), .CONVERT_EN(conv), .STATUS_BYTE_OC_WARN(sbyte),
    .STATUS_WORD_OC_WARN(sword), .ALERT_LINE_N(alert_n));
  task automatic close_out;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk_rsp(input ivt_rsp_t got, input ivt_rsp_t exp);
    comparisons++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR %0t rsp %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_out(input logic [3:0] got, input logic [3:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR %0t outputs %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [7:0] c, input logic [15:0] e);
    ivt_rsp_t r;
    host_u.xfer(1'b0, c, 16'h0000, r);
    chk_rsp(r, {1'b1, 1'b0, e});
  endtask
  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    ivt_rsp_t r;
    host_u.xfer(1'b1, c, d, r);
    chk_rsp(r, {1'b1, 1'b0, 16'h0000});
  endtask
  task automatic wr_rd(input logic [7:0] c, input logic [15:0] d);
    ivt_rsp_t rw;
    ivt_rsp_t rr;
    host_u.xfer_pair(c, d, rw, rr);
    chk_rsp(rw, {1'b1, 1'b0, 16'h0000});
    chk_rsp(rr, {1'b1, 1'b0, 4'h0, d[11:0]});
  endtask
  // expected order: convert, byte flag, word flag, alert_n
  task automatic drive(input logic [11:0] v, input logic [11:0] i,
    input logic p, input logic c, input logic [3:0] e);
    @(posedge clk);
    vin <= v;
    iout <= i;
    ok <= p;
    clr <= c;
    repeat (2) @(posedge clk);
    #1 chk_out({conv, sbyte, sword, alert_n}, e);
  endtask
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 1000)
    begin
      errors++;
      close_out();
    end
  end
  initial
  begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rd(CMD_INPUT_START_THRESHOLD, 16'h001d);
    rd(CMD_INPUT_STOP_THRESHOLD, 16'h001b);
    rd(CMD_OVERCURRENT_WARNING_THRESHOLD, {FIXED_UPPER, OC_WARN_RESET});
    wr(CMD_INPUT_START_THRESHOLD, 16'hf030);
    rd(CMD_INPUT_START_THRESHOLD, 16'h0030);
    wr(CMD_INPUT_STOP_THRESHOLD, 16'h002c);
    rd(CMD_INPUT_STOP_THRESHOLD, 16'h002c);
    wr(CMD_OVERCURRENT_WARNING_THRESHOLD, 16'h0100);
    rd(CMD_OVERCURRENT_WARNING_THRESHOLD, 16'h0100);
    wr_rd(CMD_OVERCURRENT_WARNING_THRESHOLD, 16'h5abc);
    wr_rd(CMD_OVERCURRENT_WARNING_THRESHOLD, 16'h0100);
    host_u.xfer(1'b0, 8'h00, 16'h0000, nr);
    chk_rsp(nr, {1'b0, 1'b1, 16'h0000});
    drive(12'h02f, 12'h000, 1'b1, 1'b0, 4'h1);
    drive(12'h030, 12'h000, 1'b0, 1'b0, 4'h1);
    drive(12'h030, 12'h000, 1'b1, 1'b0, 4'h9);
    drive(12'h02d, 12'h000, 1'b0, 1'b0, 4'h9);
    drive(12'h02c, 12'h000, 1'b0, 1'b0, 4'h1);
    drive(12'h02f, 12'h000, 1'b1, 1'b0, 4'h1);
    drive(12'h030, 12'h000, 1'b1, 1'b0, 4'h9);
    drive(12'h030, 12'h100, 1'b1, 1'b0, 4'h9);
    drive(12'h030, 12'h101, 1'b1, 1'b0, 4'he);
    drive(12'h030, 12'h000, 1'b1, 1'b0, 4'he);
    drive(12'h030, 12'h000, 1'b1, 1'b1, 4'h9);
    drive(12'h030, 12'h101, 1'b1, 1'b1, 4'he);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(CMD_INPUT_START_THRESHOLD, 16'h001d);
    rd(CMD_INPUT_STOP_THRESHOLD, 16'h001b);
    close_out();
  end
endmodule
`default_nettype wire
